// file: rtl/acr_readout.sv
// Conversion start, mode choice and serial result readout of a
// 16-bit sampling converter, select mode and chain mode.
// Assumes the pins arrive asynchronously and are sampled here; the
// result word comes from the analog side and is stable at completion.
//
// What this block does
// - Select start: convert, select mode, output released
// - Serial input and start low: drive low
// - Select busy: output released then driven low
// - After conversion, acquire and power down
// - Shift MSB first on clock falling edges
// - Select busy ends at 17th fall or serial input high
// - Serial input low, clock low: chain, no busy
// - Chain no busy: MSB out at completion
// - Chain: serial input shifts in on falls
// - Serial input low, clock high: chain, busy
// - Chain busy: output high at completion
// - Serial input level at start picks mode
// - Word is 16 bits; select no-busy ends after 16
`timescale 1ns/1ns
`include "acr_defines.svh"
module acr_readout
   import acr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic conv_start_i,
   input wire logic serial_in_i,
   input wire logic sck_i,
   input wire logic [15:0] sample_i,
   output logic serial_out_o,
   output logic serial_out_oe_n_o,
   output logic conv_active_o,
   output logic chain_mode_o,
   output logic busy_ind_o
);
   logic [2:0] pin_raw; // Pins in order: clock, serial input, start
   logic [2:0] pin_lvl; // Filtered pin levels
   logic cnv_f; // Filtered start line
   logic sdi_f; // Filtered serial input
   logic sck_f; // Filtered serial clock
   logic cnv_prev_q; // Start line one cycle ago
   logic sck_prev_q; // Serial clock one cycle ago
   logic cnv_rise; // Start line rising edge
   logic sck_fall; // Serial clock falling edge
   acr_state_type state_q; // Converter phase
   logic chain_q; // Chain mode chosen
   logic busy_q; // Busy indicator in effect
   logic sel_q; // Select mode word opened by serial input
   logic [8:0] conv_cnt_q; // Cycles spent converting
   logic [4:0] fall_cnt_q; // Falling edges while driving
   logic [16:0] sr_q; // Readout register, top bit drives the pin
   logic oe_n_q; // Output enable, low while driving
   logic conv_active_q; // Conversion circuitry powered
   logic start_w; // Conversion begins
   logic done_w; // Conversion completes this cycle
   logic busy_end_w; // Busy indicator decision at completion
   logic [16:0] load_w; // Register image at completion
   logic [16:0] shift_w; // Register image after one falling edge
   logic [4:0] last_w; // Falling edges that end a select readout
   logic cs_stop_w; // Select readout ends
   logic cs_open_w; // Select no-busy word opened
   logic read_quit_w; // Start line dropped, readout over
   logic [8:0] act_len_q; // Powered cycles, counted apart for the check

   // Pins cross into the system clock through filtered synchronisers
   assign pin_raw = {sck_i, serial_in_i, conv_start_i};
   generate
      for (genvar g = 0; g < 3; g++) begin : g_sync
         acr_sync3 u_sync (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .async_i(pin_raw[g]),
            .level_o(pin_lvl[g])
         );
      end
   endgenerate
   assign cnv_f = pin_lvl[0];
   assign sdi_f = pin_lvl[1];
   assign sck_f = pin_lvl[2];

   // Edge detectors work on filtered levels only
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnv_prev_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end else begin
         cnv_prev_q <= cnv_f;
         sck_prev_q <= sck_f;
      end
   end
   assign cnv_rise = cnv_f & ~cnv_prev_q;
   assign sck_fall = ~sck_f & sck_prev_q;

   // Decoding of the sequence
   assign start_w = (state_q == ACR_IDLE) && cnv_rise;
   // Fixed at the least time; the window check below guards the bound
   assign done_w = (state_q == ACR_CONV) &&
                   (conv_cnt_q == 9'(`ACR_CONV_MIN_CYC - 1));
   // Select mode: busy if either line is low at the end
   assign busy_end_w = chain_q ? busy_q : (~cnv_f | ~sdi_f);
   // Busy modes place a start bit in front: low in select, high in chain
   assign load_w = busy_end_w ? {chain_q, sample_i} : {sample_i, 1'b0};
   // Without busy the spare low bit is skipped so upstream data follows
   assign shift_w = busy_q ? {sr_q[15:0], sdi_f} :
                    {sr_q[15:1], sdi_f, 1'b0};
   assign last_w = busy_q ? `ACR_FALLS_BUSY : `ACR_FALLS_NOBUSY;
   assign cs_stop_w = (state_q == ACR_READ) && !chain_q &&
                      ((sdi_f && (busy_q || sel_q)) ||
                       (sck_fall && !oe_n_q &&
                        fall_cnt_q == last_w - 5'h01));
   assign cs_open_w = (state_q == ACR_READ) && !chain_q && !busy_q &&
                      !sel_q && !sdi_f;
   assign read_quit_w = (state_q == ACR_READ) && !cnv_f;

   // Converter sequence: acquire, convert, read out
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_q <= ACR_IDLE;
         chain_q <= 1'b0;
         busy_q <= 1'b0;
         sel_q <= 1'b0;
         conv_cnt_q <= 9'h000;
         fall_cnt_q <= 5'h00;
         sr_q <= 17'h00000;
         oe_n_q <= 1'b1;
         conv_active_q <= 1'b0;
      end else begin
         unique case (state_q)
            ACR_IDLE: begin
               if (start_w) begin
                  // Serial input level picks the mode, clock the busy in chain mode
                  state_q <= ACR_CONV;
                  chain_q <= ~sdi_f;
                  busy_q <= ~sdi_f & sck_f;
                  sel_q <= 1'b0;
                  conv_cnt_q <= 9'h000;
                  fall_cnt_q <= 5'h00;
                  sr_q <= 17'h00000;
                  oe_n_q <= sdi_f;
                  conv_active_q <= 1'b1;
               end else begin
                  // Idle pin: low when both lines low, else released
                  oe_n_q <= cnv_f | sdi_f;
               end
            end
            ACR_CONV: begin
               conv_cnt_q <= conv_cnt_q + 9'h001;
               if (done_w) begin
                  // Conversion ignores the start line until it ends
                  state_q <= ACR_READ;
                  busy_q <= busy_end_w;
                  sr_q <= load_w;
                  oe_n_q <= ~(chain_q | busy_end_w);
                  conv_active_q <= 1'b0;
               end
            end
            ACR_READ: begin
               if (read_quit_w || cs_stop_w) begin
                  state_q <= ACR_IDLE;
                  sr_q <= 17'h00000;
                  oe_n_q <= 1'b1;
               end else begin
                  if (cs_open_w) begin
                     sel_q <= 1'b1;
                     oe_n_q <= 1'b0;
                  end
                  if (sck_fall) begin
                     // Bits move only on falls, so stay valid on rises
                     sr_q <= shift_w;
                     if (!oe_n_q) begin
                        fall_cnt_q <= fall_cnt_q + 5'h01;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Outputs straight from flip-flops
   assign serial_out_o = sr_q[16];
   assign serial_out_oe_n_o = oe_n_q;
   assign conv_active_o = conv_active_q;
   assign chain_mode_o = chain_q;
   assign busy_ind_o = busy_q;

   // Helper for the window check: counts powered cycles on its own, so
   // a wrong completion count in the sequencer cannot hide from it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         act_len_q <= 9'h000;
      end else if (conv_active_q) begin
         act_len_q <= act_len_q + 9'h001;
      end else begin
         act_len_q <= 9'h000;
      end
   end

   // Checks on the sequence
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   a_select_start: assert property (start_w && sdi_f |=>
      serial_out_oe_n_o && !chain_mode_o && conv_active_o)
      else $error("select start did not release the output");
   a_idle_drive_low: assert property (
      (state_q == ACR_IDLE) && !cnv_f && !sdi_f |=>
      !serial_out_oe_n_o && !serial_out_o)
      else $error("idle low lines did not drive output low");
   a_busy_low_edge: assert property (
      done_w && !chain_q && busy_end_w |->
      serial_out_oe_n_o ##1 (!serial_out_oe_n_o && !serial_out_o))
      else $error("select busy did not go from released to low");
   a_power_down: assert property (done_w |=> !conv_active_o [*2])
      else $error("conversion circuitry stayed powered");
   a_shift_msb: assert property (
      (state_q == ACR_READ) && cnv_f && !cs_stop_w && sck_fall |=>
      serial_out_o == $past(sr_q[15]))
      else $error("output did not advance one bit on a fall");
   a_chain_pick: assert property (start_w && !sdi_f |=>
      chain_mode_o && busy_ind_o == $past(sck_f))
      else $error("chain mode or busy choice wrong");
   a_chain_msb: assert property (done_w && chain_q && !busy_q |=>
      !serial_out_oe_n_o && serial_out_o == $past(sample_i[15]))
      else $error("chain result MSB not presented");
   a_chain_feed: assert property (
      (state_q == ACR_READ) && chain_q && cnv_f && sck_fall |=>
      (busy_q ? sr_q[0] : sr_q[1]) == $past(sdi_f))
      else $error("serial input not shifted in");
   a_chain_busy_high: assert property (done_w && chain_q && busy_q |=>
      !serial_out_oe_n_o && serial_out_o)
      else $error("chain busy indicator not high");
   a_select_end: assert property (
      (state_q == ACR_READ) && !chain_q && cnv_f && sck_fall &&
      !oe_n_q && fall_cnt_q == last_w - 5'h01 |=>
      serial_out_oe_n_o && (state_q == ACR_IDLE))
      else $error("select readout did not end at last fall");
   a_conv_window: assert property ($fell(conv_active_o) |->
      act_len_q >= 9'(`ACR_CONV_MIN_CYC) &&
      act_len_q <= 9'(`ACR_CONV_MAX_CYC))
      else $error("conversion time outside window");
endmodule // acr_readout

// file: common/acr_defines.svh
// Constants of the converter start and serial readout block.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// Result word and readout register widths
`define ACR_WORD_BITS 16
`define ACR_SR_BITS 17

// System clock period in ns
`define ACR_CLK_NS 8

// Conversion time window in ns, plain defaults
`define ACR_CONV_MIN_NS 400
`define ACR_CONV_MAX_NS 2000

// Window in clock cycles: least rounds up, longest rounds down
`define ACR_CONV_MIN_CYC ((`ACR_CONV_MIN_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_CONV_MAX_CYC (`ACR_CONV_MAX_NS / `ACR_CLK_NS)

// Falling edges that close a select-mode readout
`define ACR_FALLS_NOBUSY 5'h10
`define ACR_FALLS_BUSY 5'h11

`endif

// file: common/acr_pkg.sv
// Types of the converter start and serial readout block.
// Assumes nothing of its surroundings.
package acr_pkg;

   // Phase of the converter
   typedef enum logic [1:0] {
      ACR_IDLE,
      ACR_CONV,
      ACR_READ
   } acr_state_type;

endpackage

// file: rtl/acr_sync3.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes an asynchronous input and a synchronous active-high reset.
`timescale 1ns/1ns
module acr_sync3 (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic level_o
);
   logic s1_q; // First stage, read only by the second
   logic s2_q; // Second stage
   logic s3_q; // Third stage
   logic level_q; // Filtered level

   // A change counts once the second and third stages agree
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign level_o = level_q;
endmodule // acr_sync3

// file: bench/acr_host_model.sv
// Host model: drives the start, serial input and serial clock pins,
// and plays an upstream neighbour that feeds the chain on serial input.
`timescale 1ns/1ns
module acr_host_model (
   input wire logic clk_sys_i,
   output logic conv_start_o,
   output logic serial_in_o,
   output logic sck_o
);
   logic sel_q; // Serial input level when nothing is fed
   logic feed_q; // High while the upstream neighbour drives the line
   logic [15:0] up_q; // Word still held by the upstream neighbour

   initial begin
      conv_start_o = 1'b0;
      sck_o = 1'b0;
      sel_q = 1'b0;
      feed_q = 1'b0;
      up_q = 16'h0000;
   end

   // Chained devices pass their word straight onto our serial input
   assign serial_in_o = feed_q ? up_q[15] : sel_q;

   // Pins change just after a clock edge
   task automatic pins(input logic cs, input logic si, input logic ck);
      @(posedge clk_sys_i);
      #1;
      conv_start_o = cs;
      sel_q = si;
      sck_o = ck;
   endtask

   // Loads the neighbour's word and lets it drive the line
   task automatic feed(input logic on, input logic [15:0] w);
      up_q = w;
      feed_q = on;
   endtask

   // One 125 ns link clock cycle, falling half first
   task automatic fall_rise();
      sck_o = 1'b0;
      #62;
      sck_o = 1'b1;
      #63;
   endtask

   // Neighbour moves on after each fall; hold time kept short of a cycle
   always @(negedge sck_o) begin
      #10;
      up_q = {up_q[14:0], ~up_q[15]};
   end
endmodule // acr_host_model

// file: bench/acr_readout_tb_top.sv
// Testbench of the converter start and serial readout block.
// Assumes the host model drives all pins; serial output has a pull-up.
`timescale 1ns/1ns
`include "acr_defines.svh"
module acr_readout_tb_top;
   logic clk_sys_i = 1'b0; // System clock
   logic rst_i = 1'b1; // Synchronous reset
   logic [15:0] sample = 16'h0000; // Result word of the analog side
   logic conv_start, serial_in, sck; // Host pins
   logic serial_out, sdo_oe_n, conv_active, chain_mode, busy_ind;
   wire sdo_line = sdo_oe_n ? 1'b1 : serial_out; // Pulled-up line
   int fails = 0;
   int checks_done = 0;
   int act_n = 0; // Cycles the conversion circuitry stayed powered

   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (conv_active === 1'b1) act_n++;

   acr_readout uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .conv_start_i(conv_start), .serial_in_i(serial_in), .sck_i(sck),
      .sample_i(sample), .serial_out_o(serial_out),
      .serial_out_oe_n_o(sdo_oe_n), .conv_active_o(conv_active),
      .chain_mode_o(chain_mode), .busy_ind_o(busy_ind));
   acr_host_model u_host (.clk_sys_i(clk_sys_i),
      .conv_start_o(conv_start), .serial_in_o(serial_in), .sck_o(sck));

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Start with the mode pins settled well before the start edge
   task automatic begin_conv(input logic si, input logic ck);
      u_host.pins(1'b0, si, ck);
      repeat (6) @(posedge clk_sys_i);
      act_n = 0;
      u_host.pins(1'b1, si, ck);
      repeat (8) @(posedge clk_sys_i);
      #1;
      chk(conv_active, 1'b1);
   endtask

   // Waits out the conversion, bounded, then checks its length
   task automatic conv_wait();
      repeat (300) if (conv_active === 1'b1) @(posedge clk_sys_i);
      #1;
      chk(act_n >= `ACR_CONV_MIN_CYC && act_n <= `ACR_CONV_MAX_CYC, 1);
      chk(conv_active, 1'b0);
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask

   // Line sampled just before each fall, first bit at index n-1
   task automatic read_bits(input int n, input logic [32:0] exp);
      @(posedge clk_sys_i);
      #1;
      u_host.sck_o = 1'b1;
      #63;
      for (int i = n - 1; i >= 0; i--) begin
         chk(sdo_line, exp[i]);
         u_host.fall_rise();
      end
   endtask

   // Both lines low: line must be driven low
   task automatic idle_low();
      u_host.feed(1'b0, 16'h0000);
      u_host.pins(1'b0, 1'b0, 1'b0);
      repeat (8) @(posedge clk_sys_i);
      #1;
      chk({sdo_oe_n, serial_out}, 2'h0);
   endtask

   task automatic t_sel_busy();
      sample = 16'hc3a5;
      begin_conv(1'b1, 1'b0);
      chk({chain_mode, sdo_oe_n}, 2'h1);
      u_host.pins(1'b1, 1'b0, 1'b0);
      conv_wait();
      chk({busy_ind, sdo_oe_n, serial_out}, 3'h4);
      read_bits(17, {1'b0, sample});
      chk(sdo_oe_n, 1'b1);
      idle_low();
   endtask

   task automatic t_sel_nobusy();
      sample = 16'h5a3c;
      begin_conv(1'b1, 1'b0);
      conv_wait();
      chk({busy_ind, sdo_oe_n}, 2'h1);
      u_host.pins(1'b1, 1'b0, 1'b0);
      repeat (8) @(posedge clk_sys_i);
      read_bits(16, {17'h0, sample});
      chk(sdo_oe_n, 1'b1);
      idle_low();
   endtask

   // Chain of two, optionally with the busy start bit in front
   task automatic t_chain(input logic bsy, input logic [15:0] up);
      sample = bsy ? 16'h0f71 : 16'h9be1;
      begin_conv(1'b0, bsy);
      chk({chain_mode, busy_ind}, {1'b1, bsy});
      u_host.feed(1'b1, up);
      conv_wait();
      chk({sdo_oe_n, sdo_line}, {1'b0, bsy | sample[15]});
      if (bsy) read_bits(33, {1'b1, sample, up});
      else read_bits(32, {1'b0, sample, up});
      idle_low();
   endtask

   // Readout cut short: serial input high in select, start low in chain
   task automatic t_cut(input logic chn);
      sample = 16'hab5c;
      begin_conv(~chn, 1'b0);
      u_host.pins(1'b1, 1'b0, 1'b0);
      conv_wait();
      read_bits(4, {17'h0, sample} >> (chn ? 12 : 13));
      // Select releases the line; chain goes idle and drives it low
      u_host.pins(~chn, ~chn, 1'b1);
      repeat (8) @(posedge clk_sys_i);
      #1;
      chk({sdo_oe_n, sdo_line}, {~chn, ~chn});
      idle_low();
   endtask

   initial begin
      repeat (4) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      idle_low();
      t_sel_busy();
      t_sel_nobusy();
      t_chain(1'b0, 16'h3c96);
      t_chain(1'b1, 16'he248);
      t_cut(1'b0);
      t_cut(1'b1);
      close_out();
   end

   // Whole run needs about 20 us; cut a hang well past that
   initial begin
      #100000;
      fails++;
      close_out();
   end
endmodule // acr_readout_tb_top
